// File: rtl/tsc_pkg.sv
// Constants shared by the trace time stamp counter design
`default_nettype none
package tsc_pkg;
  // ***************************************************************
  // Counter and selector
  // ***************************************************************
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] POS_GATE_FIRST = 4'h5;
  localparam logic [3:0] POS_LAST = 4'h9;
  localparam logic [2:0] N_BASES = 3'h5;
  localparam int SYNC_STAGES = 3;
  // ***************************************************************
  // Time base
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BASE_TICK_PS = 100000; // Finest tick, 0.1 us
  localparam int BASE_DIV = BASE_TICK_PS / CLK_PERIOD_PS;
  localparam int DECADE = 10;
  localparam int N_DECADES = 4;
endpackage
`default_nettype wire

// File: rtl/tsc_tick_div.sv
// Decade divider chain that makes the selected time base tick
`timescale 1ns/100ps
`default_nettype none
module tsc_tick_div
  import tsc_pkg::*;
#(
  parameter int PRE_DIV = BASE_DIV,
  parameter int STAGES = N_DECADES
) (
  input wire logic clk,
  input wire logic nrst,
  tsc_tick_if.src tk
);
  localparam int PW = $clog2(PRE_DIV);
  localparam int DW = $clog2(DECADE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRE_DIV - 1);
  localparam logic [DW-1:0] DEC_LAST = DW'(DECADE - 1);

  logic [PW-1:0] pre_q;
  logic [STAGES:0] pulse;
  logic tick_q;

  // ***************************************************************
  // Prescaler down to the finest base
  // ***************************************************************
  assign pulse[0] = (pre_q == PRE_LAST);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pulse[0] ? '0 : PW'(pre_q + 1'b1);
    end
  end

  // Each stage divides the previous pulse by ten
  genvar g;
  generate
    for (g = 1; g <= STAGES; g++) begin : g_dec
      logic [DW-1:0] dec_q;
      assign pulse[g] = pulse[g-1] && (dec_q == DEC_LAST);
      always_ff @(posedge clk) begin
        if (!nrst) begin
          dec_q <= '0;
        end else if (pulse[g-1]) begin
          dec_q <= pulse[g] ? '0 : DW'(dec_q + 1'b1);
        end
      end
    end
  endgenerate

  // Registered select keeps the tick a clean one-cycle pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= pulse[tk.base_sel];
    end
  end
  assign tk.tick = tick_q;

  property p_tick_single;
    @(posedge clk) disable iff (!nrst)
    tick_q |=> !tick_q [*8];
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("Tick pulse longer than one cycle or too frequent");
endmodule // tsc_tick_div
`default_nettype wire

// File: rtl/tsc_tick_if.sv
// Tick selection and tick pulse between counter and divider
`timescale 1ns/100ps
`default_nettype none
interface tsc_tick_if;
  logic [2:0] base_sel;
  logic tick;
  modport src (input base_sel, output tick);
  modport snk (output base_sel, input tick);
endinterface
`default_nettype wire

// File: rtl/tsc_top.sv
// Trace time stamp counter with absolute and relative stamping
`timescale 1ns/100ps
`default_nettype none
module tsc_top
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] mode_sel,
  input wire logic rel_mode,
  input wire logic occ_mode,
  input wire logic trigger_input,
  input wire logic manual_clear,
  input wire logic capture_start,
  input wire logic trace_cycle,
  input wire logic event_qual,
  output logic [CNT_W-1:0] stamp_q,
  output logic stamp_valid_q,
  output logic [CNT_W-1:0] abs_count_q,
  output logic overflow_q
);
  tsc_tick_if tk ();

  logic [SYNC_STAGES-1:0] trig_s_q;
  logic [SYNC_STAGES-1:0] mclr_s_q;
  logic trig_lvl_q;
  logic mclr_lvl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last_q;
  logic first_q;
  logic ovf_d;

  // ***************************************************************
  // Mode decoding
  // ***************************************************************
  wire clear_mode = (mode_sel < POS_GATE_FIRST);
  wire gate_mode = !clear_mode && (mode_sel <= POS_LAST);
  wire [3:0] base_pos = clear_mode ? mode_sel : 4'(mode_sel - POS_GATE_FIRST);
  assign tk.base_sel = gate_mode || clear_mode ? base_pos[2:0] : 3'h0;

  tsc_tick_div u_div (
    .clk (clk),
    .nrst (nrst),
    .tk (tk)
  );

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // A level is accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_s_q <= '0;
      mclr_s_q <= '0;
      trig_lvl_q <= 1'b0;
      mclr_lvl_q <= 1'b0;
    end else begin
      trig_s_q <= {trig_s_q[SYNC_STAGES-2:0], trigger_input};
      mclr_s_q <= {mclr_s_q[SYNC_STAGES-2:0], manual_clear};
      if (trig_s_q[1] == trig_s_q[2]) trig_lvl_q <= trig_s_q[2];
      if (mclr_s_q[1] == mclr_s_q[2]) mclr_lvl_q <= mclr_s_q[2];
    end
  end

  // ***************************************************************
  // Count control
  // ***************************************************************
  // Positions above nine are unused and hold the count; only the manual clear still zeroes it
  wire trig_clr = clear_mode && trig_lvl_q;
  wire clr = mclr_lvl_q || trig_clr;
  wire run = clear_mode || (gate_mode && trig_lvl_q);
  wire step = occ_mode ? event_qual : tk.tick;
  wire inc = run && step && !clr;
  wire wrap = inc && (cnt_q == CNT_MAX);

  // Clear wins over counting so a trigger edge starts from zero
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = CNT_ZERO;
    end else if (inc) begin
      cnt_d = cnt_q + CNT_ONE; // Wraps to zero past max
    end
  end

  // Overflow is sticky; only the manual clear drops it
  assign ovf_d = wrap || (overflow_q && !mclr_lvl_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= CNT_ZERO;
      overflow_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      overflow_q <= ovf_d;
    end
  end

  // Compare value for the event monitor
  always_ff @(posedge clk) begin
    if (!nrst) begin
      abs_count_q <= CNT_ZERO;
    end else begin
      abs_count_q <= cnt_d;
    end
  end

  // ***************************************************************
  // Trace stamping
  // ***************************************************************
  // Stamp uses the count before this cycle's update, as the trace
  // record is taken at the same edge the count may move.
  wire [CNT_W-1:0] rel_val = cnt_q - last_q;
  wire first_rec = capture_start || first_q;
  wire [CNT_W-1:0] stamp_d = (rel_mode && !first_rec) ? rel_val : cnt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stamp_q <= CNT_ZERO;
      stamp_valid_q <= 1'b0;
      last_q <= CNT_ZERO;
      first_q <= 1'b1;
    end else begin
      stamp_valid_q <= trace_cycle;
      if (trace_cycle) begin
        // First record of a capture is absolute
        stamp_q <= stamp_d;
        last_q <= cnt_q;
        first_q <= 1'b0;
      end else if (capture_start) begin
        first_q <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_abs_stamp;
    @(posedge clk) disable iff (!nrst)
    trace_cycle && !rel_mode |=> stamp_valid_q && stamp_q == $past(cnt_q);
  endproperty
  a_abs_stamp: assert property (p_abs_stamp)
    else $error("Absolute stamp differs from count");

  property p_rel_stamp;
    @(posedge clk) disable iff (!nrst)
    trace_cycle && rel_mode && !first_q && !capture_start
      |=> stamp_q == CNT_W'($past(cnt_q) - $past(last_q));
  endproperty
  a_rel_stamp: assert property (p_rel_stamp)
    else $error("Relative stamp is not the count difference");

  property p_first_abs;
    @(posedge clk) disable iff (!nrst)
    trace_cycle && rel_mode && (capture_start || first_q)
      |=> stamp_q == $past(cnt_q);
  endproperty
  a_first_abs: assert property (p_first_abs)
    else $error("First relative record not absolute");

  property p_cmp_value;
    @(posedge clk) disable iff (!nrst)
    1'b1 |=> abs_count_q == cnt_q;
  endproperty
  a_cmp_value: assert property (p_cmp_value)
    else $error("Compare value lags the count");

  property p_occ;
    @(posedge clk) disable iff (!nrst)
    occ_mode && run && event_qual && !clr && cnt_q != CNT_MAX
      |=> cnt_q == CNT_W'($past(cnt_q) + CNT_ONE);
  endproperty
  a_occ: assert property (p_occ)
    else $error("Occurrence not counted");

  property p_wrap;
    @(posedge clk) disable iff (!nrst)
    wrap |=> cnt_q == CNT_ZERO && overflow_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Counter did not wrap with overflow");

  property p_trig_clr;
    @(posedge clk) disable iff (!nrst)
    clear_mode && trig_lvl_q |=> cnt_q == CNT_ZERO;
  endproperty
  a_trig_clr: assert property (p_trig_clr)
    else $error("Trigger did not clear the count");

  property p_gate_hold;
    @(posedge clk) disable iff (!nrst)
    gate_mode && !trig_lvl_q && !mclr_lvl_q |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("Count moved with trigger low in gated mode");

  property p_man_clr;
    @(posedge clk) disable iff (!nrst)
    mclr_lvl_q |=> cnt_q == CNT_ZERO && !overflow_q;
  endproperty
  a_man_clr: assert property (p_man_clr)
    else $error("Manual clear failed");
endmodule // tsc_top
`default_nettype wire

// File: tb/tsc_top_tb.sv
// Self-checking bench for the trace time stamp counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tsc_top_tb
  import tsc_pkg::*;
;
  logic clk, nrst, rel_mode, occ_mode, trig, mclr, cap, trc, evq;
  logic [3:0] mode_sel;
  logic [CNT_W-1:0] stamp, abs_cnt;
  logic valid, ovf;
  int fail_count = 0;
  int checks_done = 0;
  tsc_top dut (.clk(clk), .nrst(nrst), .mode_sel(mode_sel),
    .rel_mode(rel_mode), .occ_mode(occ_mode), .trigger_input(trig),
    .manual_clear(mclr), .capture_start(cap), .trace_cycle(trc),
    .event_qual(evq), .stamp_q(stamp), .stamp_valid_q(valid),
    .abs_count_q(abs_cnt), .overflow_q(ovf));
  tsc_trace_model mdl (.clk(clk), .trace_cycle(trc), .capture_start(cap),
    .stamp_q(stamp), .stamp_valid_q(valid));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Back-to-back qualifying events, one per cycle
  task automatic ev(input int n);
    repeat (n) begin
      @(negedge clk);
      evq = 1'b1;
    end
    @(negedge clk);
    evq = 1'b0;
  endtask
  // Covers the pin synchroniser latency with margin
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  task automatic rec(input logic first, input logic [CNT_W-1:0] exp);
    logic [CNT_W-1:0] s;
    logic ok;
    mdl.record(first, s, ok);
    `CHK(ok, 1'b1)
    `CHK(s, exp)
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset();
    `CHK({abs_cnt, stamp, ovf}, 33'h0)
  endtask
  task automatic t_abs_rel();
    ev(5);
    `CHK(abs_cnt, 16'h0005)
    rec(1'b0, 16'h0005);
    rel_mode = 1'b1;
    rec(1'b1, 16'h0005);
    ev(3);
    rec(1'b0, 16'h0003);
    rec(1'b0, 16'h0000);
    rel_mode = 1'b0;
  endtask
  task automatic t_trig_clear();
    trig = 1'b1;
    settle();
    ev(2);
    `CHK(abs_cnt, 16'h0000)
    trig = 1'b0;
    settle();
    ev(4);
    rec(1'b0, 16'h0004);
  endtask
  task automatic t_gate();
    mode_sel = 4'h5;
    ev(3);
    `CHK(abs_cnt, 16'h0004)
    trig = 1'b1;
    settle();
    ev(3);
    `CHK(abs_cnt, 16'h0007)
    trig = 1'b0;
    settle();
    mode_sel = 4'h0;
  endtask
  task automatic t_wrap();
    mclr = 1'b1;
    settle();
    mclr = 1'b0;
    settle();
    `CHK(abs_cnt, 16'h0000)
    ev(65535);
    `CHK({ovf, abs_cnt}, 17'h0ffff)
    ev(1);
    `CHK({ovf, abs_cnt}, 17'h10000)
    ev(2);
    `CHK({ovf, abs_cnt}, 17'h10002)
    mclr = 1'b1;
    settle();
    mclr = 1'b0;
    `CHK({ovf, abs_cnt}, 17'h00000)
  endtask
  // Two periods of a periodic tick hold exactly two ticks, any phase
  task automatic t_tick();
    logic [CNT_W-1:0] c0, d;
    int p;
    occ_mode = 1'b0;
    p = BASE_DIV;
    for (int b = 0; b < 3; b++) begin
      mode_sel = 4'(b);
      repeat (p) @(negedge clk);
      c0 = abs_cnt;
      repeat (2 * p) @(negedge clk);
      d = abs_cnt - c0;
      `CHK(d, 16'h0002)
      p = p * DECADE;
    end
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    mode_sel = 4'h0;
    rel_mode = 1'b0;
    occ_mode = 1'b1;
    trig = 1'b0;
    mclr = 1'b0;
    evq = 1'b0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_abs_rel();
    t_trig_clear();
    t_gate();
    t_wrap();
    t_tick();
    tally_and_finish();
  end
  // Watchdog past the expected run of about 75,000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // tsc_top_tb
`default_nettype wire

// File: tb/tsc_trace_model.sv
// Emulator trace capture model on the far side of the stamp port
`timescale 1ns/100ps
`default_nettype none
module tsc_trace_model
  import tsc_pkg::*;
(
  input wire logic clk,
  output logic trace_cycle,
  output logic capture_start,
  input wire logic [CNT_W-1:0] stamp_q,
  input wire logic stamp_valid_q
);
  // Port is owned by the counter alone, no pod shares it
  initial begin
    trace_cycle = 1'b0;
    capture_start = 1'b0;
  end
  // One traced cycle; ok only if valid stands for exactly one cycle
  task automatic record(input logic first, output logic [CNT_W-1:0] s,
                        output logic ok);
    @(negedge clk);
    trace_cycle = 1'b1;
    capture_start = first;
    @(negedge clk);
    trace_cycle = 1'b0;
    capture_start = 1'b0;
    ok = (stamp_valid_q === 1'b1);
    s = stamp_q;
    @(negedge clk);
    ok = ok && (stamp_valid_q === 1'b0);
  endtask
endmodule // tsc_trace_model
`default_nettype wire
